// ==== rtl/cpu_register_set.sv ====
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "cpu_regs_map.svh"

module cpu_register_set (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Operation port from the sequencer
  input  wire logic               op_valid,
  input  wire cpu_regs_pkg::op_t  op_code,
  input  wire logic               op_on_index,
  input  wire logic [15:0]        op_data,
  // Interrupt recognition
  input  wire logic               insn_boundary,
  input  wire logic               irq_pending,
  output logic                    irq_accept,
  // Reset vector fetch
  output logic                    vector_fetch,
  output logic      [15:0]        vector_addr,
  input  wire logic [7:0]         vector_byte,
  input  wire logic               vector_byte_valid,
  output logic                    run_enable,
  // Register views
  output logic      [7:0]         acc_value,
  output logic      [15:0]        index_value,
  output logic      [15:0]        stack_value,
  output logic      [15:0]        program_value,
  output logic      [7:0]         flags_value,
  // Signed branch conditions
  output logic                    branch_greater_op_true,
  output logic                    branch_greater_equal_op_true,
  output logic                    branch_less_equal_op_true,
  output logic                    branch_less_op_true
);

  logic [7:0]                  acc_q;
  logic [7:0]                  index_hi_q;
  logic [7:0]                  index_lo_q;
  logic [15:0]                 stack_q;
  logic [15:0]                 program_q;
  logic [7:0]                  flags_q;
  logic                        inhibit_q;
  logic [7:0]                  vec_hi_q;
  logic [15:0]                 vec_addr_q;
  logic [31:0]                 prdata_q;
  cpu_regs_pkg::vector_state_t vec_q;

  logic       op_go;
  logic       dest_index;
  logic [7:0] alu_l;
  logic [7:0] alu_result;
  logic       alu_we;
  logic       alu_v;
  logic       alu_h;
  logic       alu_c;
  logic [4:0] alu_upd;
  logic       wr_go;
  logic [2:0] wr_sel;
  logic       rd_setup;
  logic       mask_cleared;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] sign_extend8(input logic [7:0] b);
    sign_extend8 = {{8{b[7]}}, b};
  endfunction

  // 0 means unmapped, 1..5 select a register
  function automatic logic [2:0] reg_select(input logic [11:0] addr);
    if (addr == `OFS_ACCUMULATOR) begin
      reg_select = 3'h1;
    end else if (addr == `OFS_INDEX_PAIR) begin
      reg_select = 3'h2;
    end else if (addr == `OFS_STACK_POINTER) begin
      reg_select = 3'h3;
    end else if (addr == `OFS_PROGRAM_COUNTER) begin
      reg_select = 3'h4;
    end else if (addr == `OFS_CONDITION_FLAGS) begin
      reg_select = 3'h5;
    end else begin
      reg_select = 3'h0;
    end
  endfunction

  // ----------------------------------------
  // Operation steering
  // ----------------------------------------
  assign op_go      = op_valid && run_enable;
  assign dest_index = (op_code == cpu_regs_pkg::OP_ACC_TO_INDEX) ||
                      (op_code == cpu_regs_pkg::OP_LOAD_INDEX) ||
                      (op_on_index && (op_code != cpu_regs_pkg::OP_INDEX_TO_ACC));
  assign alu_l      = (dest_index && (op_code != cpu_regs_pkg::OP_ACC_TO_INDEX)) ||
                      (op_code == cpu_regs_pkg::OP_INDEX_TO_ACC) ? index_lo_q : acc_q;

  flag_alu u_alu (
    .op        (op_code),
    .opnd_l    (alu_l),
    .opnd_r    (op_data[7:0]),
    .c_in      (flags_q[`FLAG_C]),
    .h_in      (flags_q[`FLAG_H]),
    .result    (alu_result),
    .result_we (alu_we),
    .v_out     (alu_v),
    .h_out     (alu_h),
    .c_out     (alu_c),
    .upd       (alu_upd)
  );

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign wr_sel   = reg_select(paddr);
  assign wr_go    = psel && penable && pwrite && (wr_sel != 3'h0);
  assign rd_setup = psel && !penable;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && (wr_sel == 3'h0);
  assign prdata   = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (rd_setup) begin
      if (wr_sel == 3'h1) begin
        prdata_q <= {24'h000000, acc_q};
      end else if (wr_sel == 3'h2) begin
        prdata_q <= {16'h0000, index_hi_q, index_lo_q};
      end else if (wr_sel == 3'h3) begin
        prdata_q <= {16'h0000, stack_q};
      end else if (wr_sel == 3'h4) begin
        prdata_q <= {16'h0000, program_q};
      end else if (wr_sel == 3'h5) begin
        prdata_q <= {24'h000000, flags_q | `FLAGS_FIXED_ONES};
      end else begin
        prdata_q <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------
  // Accumulator, no reset
  // ----------------------------------------
  always_ff @(posedge pclk) begin
    if (op_go && alu_we && !dest_index) begin
      acc_q <= alu_result;
    end else if (wr_go && (wr_sel == 3'h1)) begin
      acc_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // Index pair
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_hi_q <= `INDEX_HI_RESET;
    end else if (op_go && (op_code == cpu_regs_pkg::OP_LOAD_PAIR)) begin
      index_hi_q <= op_data[15:8];
    end else if (wr_go && (wr_sel == 3'h2)) begin
      index_hi_q <= pwdata[15:8];
    end
  end

  always_ff @(posedge pclk) begin
    if (op_go && (op_code == cpu_regs_pkg::OP_LOAD_PAIR)) begin
      index_lo_q <= op_data[7:0];
    end else if (op_go && alu_we && dest_index) begin
      index_lo_q <= alu_result;
    end else if (wr_go && (wr_sel == 3'h2)) begin
      index_lo_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // Stack pointer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_q <= `STACK_RESET;
    end else if (op_go && (op_code == cpu_regs_pkg::OP_STACK_ADJUST)) begin
      stack_q <= stack_q + sign_extend8(op_data[7:0]);
    end else if (op_go && (op_code == cpu_regs_pkg::OP_STACK_POINTER_RESET)) begin
      stack_q <= {stack_q[15:8], `STACK_LOW_RESET};
    end else if (op_go && (op_code == cpu_regs_pkg::OP_PUSH)) begin
      stack_q <= stack_q - 16'h0001;
    end else if (op_go && (op_code == cpu_regs_pkg::OP_PULL)) begin
      stack_q <= stack_q + 16'h0001;
    end else if (wr_go && (wr_sel == 3'h3)) begin
      stack_q <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // Reset vector fetch
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_q      <= cpu_regs_pkg::VEC_HI;
      vec_hi_q   <= 8'h00;
      vec_addr_q <= `VECTOR_HI_ADDR;
    end else begin
      case (vec_q)
        cpu_regs_pkg::VEC_HI: begin
          if (vector_byte_valid) begin
            vec_hi_q   <= vector_byte;
            vec_addr_q <= `VECTOR_LO_ADDR;
            vec_q      <= cpu_regs_pkg::VEC_LO;
          end
        end
        cpu_regs_pkg::VEC_LO: begin
          if (vector_byte_valid) begin
            vec_q <= cpu_regs_pkg::VEC_DONE;
          end
        end
        default: begin
          vec_q <= cpu_regs_pkg::VEC_DONE;
        end
      endcase
    end
  end

  assign vector_fetch = (vec_q != cpu_regs_pkg::VEC_DONE);
  assign vector_addr  = vec_addr_q;
  assign run_enable   = (vec_q == cpu_regs_pkg::VEC_DONE);

  // ----------------------------------------
  // Program counter
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_q <= `PROGRAM_RESET;
    end else if ((vec_q == cpu_regs_pkg::VEC_LO) && vector_byte_valid) begin
      program_q <= {vec_hi_q, vector_byte};
    end else if (op_go && (op_code == cpu_regs_pkg::OP_FETCH)) begin
      program_q <= program_q + 16'h0001;
    end else if (op_go && (op_code == cpu_regs_pkg::OP_JUMP)) begin
      program_q <= op_data;
    end else if (op_go && (op_code == cpu_regs_pkg::OP_BRANCH)) begin
      program_q <= program_q + sign_extend8(op_data[7:0]);
    end else if (wr_go && (wr_sel == 3'h4)) begin
      program_q <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // Condition flags
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= `FLAGS_RESET;
    end else if (op_go && (op_code == cpu_regs_pkg::OP_LOAD_PAIR)) begin
      flags_q[`FLAG_V] <= 1'b0;
      flags_q[`FLAG_N] <= op_data[15];
      flags_q[`FLAG_Z] <= (op_data == 16'h0000);
    end else if (op_go && (op_code == cpu_regs_pkg::OP_FLAGS_LOAD)) begin
      flags_q <= op_data[7:0] | `FLAGS_FIXED_ONES;
    end else if (op_go && (op_code == cpu_regs_pkg::OP_MASK_CLEAR)) begin
      flags_q[`FLAG_I] <= 1'b0;
    end else if (op_go && ((op_code == cpu_regs_pkg::OP_MASK_SET) ||
                           (op_code == cpu_regs_pkg::OP_INT_SAVED))) begin
      flags_q[`FLAG_I] <= 1'b1;
    end else if (op_go) begin
      // Untouched bits keep their value
      if (alu_upd[4]) begin
        flags_q[`FLAG_V] <= alu_v;
      end
      if (alu_upd[3]) begin
        flags_q[`FLAG_H] <= alu_h;
      end
      if (alu_upd[2]) begin
        flags_q[`FLAG_N] <= alu_result[7];
      end
      if (alu_upd[1]) begin
        flags_q[`FLAG_Z] <= (alu_result == 8'h00);
      end
      if (alu_upd[0]) begin
        flags_q[`FLAG_C] <= alu_c;
      end
    end else if (wr_go && (wr_sel == 3'h5)) begin
      flags_q <= pwdata[7:0] | `FLAGS_FIXED_ONES;
    end
  end

  // ----------------------------------------
  // Interrupt recognition
  // ----------------------------------------
  assign mask_cleared = op_go && flags_q[`FLAG_I] &&
                        ((op_code == cpu_regs_pkg::OP_MASK_CLEAR) ||
                         ((op_code == cpu_regs_pkg::OP_FLAGS_LOAD) && !op_data[`FLAG_I]));

  // Set wins over the boundary that would clear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_q <= 1'b0;
    end else if (mask_cleared) begin
      inhibit_q <= 1'b1;
    end else if (insn_boundary) begin
      inhibit_q <= 1'b0;
    end
  end

  assign irq_accept = insn_boundary && irq_pending && run_enable &&
                      !flags_q[`FLAG_I] && !inhibit_q;

  // ----------------------------------------
  // Views and signed branch tests
  // ----------------------------------------
  assign acc_value     = acc_q;
  assign index_value   = {index_hi_q, index_lo_q};
  assign stack_value   = stack_q;
  assign program_value = program_q;
  assign flags_value   = flags_q | `FLAGS_FIXED_ONES;

  assign branch_greater_equal_op_true = !(flags_q[`FLAG_N] ^ flags_q[`FLAG_V]);
  assign branch_less_op_true          = flags_q[`FLAG_N] ^ flags_q[`FLAG_V];
  assign branch_greater_op_true       = !flags_q[`FLAG_Z] &&
                                        !(flags_q[`FLAG_N] ^ flags_q[`FLAG_V]);
  assign branch_less_equal_op_true    = flags_q[`FLAG_Z] ||
                                        (flags_q[`FLAG_N] ^ flags_q[`FLAG_V]);

endmodule

// ==== rtl/cpu_regs_map.svh ====
`ifndef CPU_REGS_MAP_SVH
`define CPU_REGS_MAP_SVH

// ----------------------------------------
// Register offsets on the bus
// ----------------------------------------
`define OFS_ACCUMULATOR     12'h000
`define OFS_INDEX_PAIR      12'h004
`define OFS_STACK_POINTER   12'h008
`define OFS_PROGRAM_COUNTER 12'h00c
`define OFS_CONDITION_FLAGS 12'h010

// ----------------------------------------
// Reset values and fixed flag bits
// ----------------------------------------
`define INDEX_HI_RESET      8'h00
`define STACK_RESET         16'h00ff
`define PROGRAM_RESET       16'h0000
`define FLAGS_RESET         8'h68
`define FLAGS_FIXED_ONES    8'h60
`define STACK_LOW_RESET     8'hff

// ----------------------------------------
// Condition flag bit positions
// ----------------------------------------
`define FLAG_V              7
`define FLAG_H              4
`define FLAG_I              3
`define FLAG_N              2
`define FLAG_Z              1
`define FLAG_C              0

// ----------------------------------------
// Vector addresses and decimal correction
// ----------------------------------------
`define VECTOR_HI_ADDR      16'hfffe
`define VECTOR_LO_ADDR      16'hffff
`define BCD_LO_FIX          8'h06
`define BCD_HI_FIX          8'h60
`define BCD_NIBBLE_MAX      4'h9
`define BCD_BYTE_MAX        8'h99

`endif

// ==== rtl/cpu_regs_pkg.sv ====
package cpu_regs_pkg;

  typedef enum logic [5:0] {
    OP_NOP         = 6'b000000, OP_LOAD_ACC     = 6'b000001, OP_STORE_ACC   = 6'b000010,
    OP_ADD         = 6'b000011, OP_ADD_CARRY    = 6'b000100, OP_SUB         = 6'b000101,
    OP_SUB_CARRY   = 6'b000110, OP_AND         = 6'b000111, OP_OR          = 6'b001000,
    OP_XOR         = 6'b001001, OP_CLEAR        = 6'b001010, OP_INCREMENT   = 6'b001011,
    OP_DECREMENT   = 6'b001100, OP_COMPLEMENT   = 6'b001101, OP_NEGATE      = 6'b001110,
    OP_SHIFT_LEFT  = 6'b001111, OP_SHIFT_RIGHT  = 6'b010000, OP_ROTATE_LEFT = 6'b010001,
    OP_ROTATE_RIGHT = 6'b010010, OP_ACC_TO_INDEX = 6'b010011, OP_INDEX_TO_ACC = 6'b010100,
    OP_DECIMAL_ADJUST = 6'b010101, OP_STACK_ADJUST = 6'b010110,
    OP_STACK_POINTER_RESET = 6'b010111, OP_MASK_CLEAR = 6'b011000,
    OP_MASK_SET    = 6'b011001, OP_FLAGS_LOAD   = 6'b011010, OP_LOAD_PAIR   = 6'b011011,
    OP_JUMP        = 6'b011100, OP_FETCH        = 6'b011101, OP_BRANCH      = 6'b011110,
    OP_INT_SAVED   = 6'b011111, OP_PUSH         = 6'b100000, OP_PULL        = 6'b100001,
    OP_BIT_CARRY   = 6'b100010, OP_LOAD_INDEX   = 6'b100011
  } op_t;

  typedef enum logic [1:0] {
    VEC_HI   = 2'b00,
    VEC_LO   = 2'b01,
    VEC_DONE = 2'b10
  } vector_state_t;

endpackage

// ==== rtl/flag_alu.sv ====
`timescale 1ns/1ps
`include "cpu_regs_map.svh"

module flag_alu (
  // Operation
  input  wire cpu_regs_pkg::op_t op,
  input  wire logic [7:0]        opnd_l,
  input  wire logic [7:0]        opnd_r,
  input  wire logic              c_in,
  input  wire logic              h_in,
  // Result
  output logic [7:0]             result,
  output logic                   result_we,
  output logic                   v_out,
  output logic                   h_out,
  output logic                   c_out,
  output logic [4:0]             upd
);

  logic [8:0] wide;
  logic [4:0] nib;
  logic       cin;
  logic       fix_lo;
  logic       fix_hi;

  // ----------------------------------------
  // Result and flags; upd is {v,h,n,z,c}
  // ----------------------------------------
  always_comb begin
    wide      = 9'h000;
    nib       = 5'h00;
    cin       = 1'b0;
    fix_lo    = 1'b0;
    fix_hi    = 1'b0;
    result    = opnd_l;
    result_we = 1'b0;
    v_out     = 1'b0;
    h_out     = h_in;
    c_out     = c_in;
    upd       = 5'b00000;
    case (op)
      cpu_regs_pkg::OP_LOAD_ACC, cpu_regs_pkg::OP_LOAD_INDEX: begin
        result    = opnd_r;
        result_we = 1'b1;
        upd       = 5'b10110;
      end
      cpu_regs_pkg::OP_STORE_ACC: begin
        upd = 5'b10110;
      end
      cpu_regs_pkg::OP_ADD, cpu_regs_pkg::OP_ADD_CARRY: begin
        cin       = (op == cpu_regs_pkg::OP_ADD_CARRY) ? c_in : 1'b0;
        wide      = {1'b0, opnd_l} + {1'b0, opnd_r} + {8'h00, cin};
        nib       = {1'b0, opnd_l[3:0]} + {1'b0, opnd_r[3:0]} + {4'h0, cin};
        result    = wide[7:0];
        result_we = 1'b1;
        h_out     = nib[4];
        c_out     = wide[8];
        v_out     = (opnd_l[7] == opnd_r[7]) && (wide[7] != opnd_l[7]);
        upd       = 5'b11111;
      end
      cpu_regs_pkg::OP_SUB, cpu_regs_pkg::OP_SUB_CARRY: begin
        cin       = (op == cpu_regs_pkg::OP_SUB_CARRY) ? c_in : 1'b0;
        wide      = {1'b0, opnd_l} - {1'b0, opnd_r} - {8'h00, cin};
        result    = wide[7:0];
        result_we = 1'b1;
        c_out     = wide[8];
        v_out     = (opnd_l[7] != opnd_r[7]) && (wide[7] != opnd_l[7]);
        upd       = 5'b10111;
      end
      cpu_regs_pkg::OP_AND, cpu_regs_pkg::OP_OR, cpu_regs_pkg::OP_XOR: begin
        if (op == cpu_regs_pkg::OP_AND) begin
          result = opnd_l & opnd_r;
        end else if (op == cpu_regs_pkg::OP_OR) begin
          result = opnd_l | opnd_r;
        end else begin
          result = opnd_l ^ opnd_r;
        end
        result_we = 1'b1;
        upd       = 5'b10110;
      end
      cpu_regs_pkg::OP_CLEAR: begin
        result    = 8'h00;
        result_we = 1'b1;
        upd       = 5'b10110;
      end
      cpu_regs_pkg::OP_INCREMENT, cpu_regs_pkg::OP_DECREMENT: begin
        result    = (op == cpu_regs_pkg::OP_INCREMENT) ? opnd_l + 8'h01 : opnd_l - 8'h01;
        result_we = 1'b1;
        v_out     = (op == cpu_regs_pkg::OP_INCREMENT) ? (opnd_l == 8'h7f) : (opnd_l == 8'h80);
        upd       = 5'b10110;
      end
      cpu_regs_pkg::OP_COMPLEMENT: begin
        result    = ~opnd_l;
        result_we = 1'b1;
        c_out     = 1'b1;
        upd       = 5'b10111;
      end
      cpu_regs_pkg::OP_NEGATE: begin
        result    = 8'h00 - opnd_l;
        result_we = 1'b1;
        v_out     = (opnd_l == 8'h80);
        c_out     = (opnd_l != 8'h00);
        upd       = 5'b10111;
      end
      cpu_regs_pkg::OP_SHIFT_LEFT, cpu_regs_pkg::OP_ROTATE_LEFT: begin
        result    = {opnd_l[6:0], (op == cpu_regs_pkg::OP_ROTATE_LEFT) & c_in};
        result_we = 1'b1;
        c_out     = opnd_l[7];
        v_out     = opnd_l[6] ^ opnd_l[7];
        upd       = 5'b10111;
      end
      cpu_regs_pkg::OP_SHIFT_RIGHT, cpu_regs_pkg::OP_ROTATE_RIGHT: begin
        result    = {(op == cpu_regs_pkg::OP_ROTATE_RIGHT) & c_in, opnd_l[7:1]};
        result_we = 1'b1;
        c_out     = opnd_l[0];
        v_out     = result[7] ^ opnd_l[0];
        upd       = 5'b10111;
      end
      cpu_regs_pkg::OP_ACC_TO_INDEX, cpu_regs_pkg::OP_INDEX_TO_ACC: begin
        result_we = 1'b1;
      end
      cpu_regs_pkg::OP_DECIMAL_ADJUST: begin
        fix_lo    = h_in || (opnd_l[3:0] > `BCD_NIBBLE_MAX);
        fix_hi    = c_in || (opnd_l > `BCD_BYTE_MAX);
        result    = opnd_l + (fix_lo ? `BCD_LO_FIX : 8'h00) + (fix_hi ? `BCD_HI_FIX : 8'h00);
        result_we = 1'b1;
        c_out     = fix_hi;
        upd       = 5'b00111;
      end
      cpu_regs_pkg::OP_BIT_CARRY: begin
        c_out = opnd_r[0];
        upd   = 5'b00001;
      end
      default: begin
        upd = 5'b00000;
      end
    endcase
  end

endmodule

// ==== test/cpu_programmer_register_set_tb_top.sv ====
`timescale 1ns/1ps
module cpu_programmer_register_set_tb_top;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata;
  logic              op_valid, op_on_index, insn_boundary, irq_pending, irq_accept;
  cpu_regs_pkg::op_t op_code;
  logic [15:0]       op_data, vector_addr, index_value, stack_value, program_value;
  logic [7:0]        vector_byte, acc_value, flags_value, a, d, fl;
  logic              vector_byte_valid, vector_fetch, run_enable;
  logic              br_gt, br_ge, br_le, br_lt, exp_irq;
  logic [15:0]       vq[$];
  logic [33:0]       exp_q[$];
  logic [33:0]       note;
  int                bad_count, checks_done, cycles, seed, s;
  cpu_register_set dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .op_valid, .op_code, .op_on_index, .op_data, .insn_boundary,
    .irq_pending, .irq_accept, .vector_fetch, .vector_addr, .vector_byte, .vector_byte_valid,
    .run_enable, .acc_value, .index_value, .stack_value, .program_value, .flags_value,
    .branch_greater_op_true(br_gt), .branch_greater_equal_op_true(br_ge),
    .branch_less_equal_op_true(br_le), .branch_less_op_true(br_lt));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // Monitor and timeout
  // ----------------------------------------
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (psel && penable && pready) begin
      note = exp_q.pop_front();
      checks_done++;
      if (pslverr !== note[32] || (note[33] && prdata !== note[31:0])) begin
        $display("Error %0t: bus answer %h %h", $time, pslverr, prdata);
        bad_count++;
      end
    end
    if (insn_boundary) begin
      checks_done++;
      if (irq_accept !== exp_irq) begin
        $display("Error %0t: interrupt accept %b", $time, irq_accept);
        bad_count++;
      end
    end
    if (vector_byte_valid) begin
      checks_done++;
      if (!vector_fetch || run_enable || vector_addr !== vq.pop_front()) begin
        $display("Error %0t: vector fetch %h", $time, vector_addr);
        bad_count++;
      end
    end
    if (cycles == 2000) begin
      $display("Error %0t: timeout", $time);
      bad_count++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] wd,
                     input logic err, input logic [31:0] rd);
    exp_q.push_back({!w, err, rd});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic op(input cpu_regs_pkg::op_t c, input logic [15:0] dd, input logic ix);
    op_valid <= 1'b1;
    op_code <= c;
    op_data <= dd;
    op_on_index <= ix;
    @(posedge pclk) op_valid <= 1'b0;
    insn_boundary <= 1'b1;
    @(posedge pclk) insn_boundary <= 1'b0;
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  initial begin
    seed = 53122;
    op_code = cpu_regs_pkg::OP_NOP;
    {psel, penable, pwrite, op_valid, op_on_index, insn_boundary, irq_pending, exp_irq} = '0;
    {vector_byte_valid, paddr, pwdata, op_data, vector_byte} = '0;
    do_reset();
    bus(1'b0, 12'h008, 32'h0, 1'b0, 32'h00ff);
    bus(1'b0, 12'h010, 32'h0, 1'b0, 32'h68);
    vq = '{16'hfffe, 16'hffff};
    vector_byte_valid <= 1'b1;
    vector_byte <= 8'h12;
    @(posedge pclk) vector_byte <= 8'h34;
    @(posedge pclk) vector_byte_valid <= 1'b0;
    @(posedge pclk);
    bus(1'b0, 12'h00c, 32'h0, 1'b0, 32'h1234);
    op(cpu_regs_pkg::OP_LOAD_PAIR, 16'habcd, 1'b0);
    op(cpu_regs_pkg::OP_INCREMENT, 16'h0, 1'b1);
    bus(1'b0, 12'h004, 32'h0, 1'b0, 32'habce);
    for (int k = 0; k < 6; k++) begin
      a = 8'($random(seed));
      d = 8'($random(seed));
      if (k == 0) {a, d} = 16'h7f01;
      irq_pending <= 1'($random(seed));
      bus(1'b1, 12'h000, {24'h0, a}, 1'b0, 32'h0);
      op(cpu_regs_pkg::OP_ADD, {8'h0, d}, 1'b0);
      s = int'($signed(a)) + int'($signed(d));
      checks_done++;
      if ({br_gt, br_ge, br_le, br_lt} !== {s > 0, s >= 0, s <= 0, s < 0}) begin
        $display("Error %0t: signed branch tests %b", $time, {br_gt, br_ge, br_le, br_lt});
        bad_count++;
      end
      fl = {(a[7] == d[7]) && (8'(a + d) >> 7 != a[7]), 2'b11, 5'(a[3:0] + d[3:0]) > 5'h0f,
            1'b1, 8'(a + d) >> 7 == 1'b1, 8'(a + d) == 8'h00, 9'(a + d) > 9'h0ff};
      bus(1'b0, 12'h000, 32'h0, 1'b0, {24'h0, 8'(a + d)});
      bus(1'b0, 12'h010, 32'h0, 1'b0, {24'h0, fl});
    end
    bus(1'b1, 12'h000, 32'h09, 1'b0, 32'h0);
    op(cpu_regs_pkg::OP_ADD, 16'h0008, 1'b0);
    op(cpu_regs_pkg::OP_DECIMAL_ADJUST, 16'h0, 1'b0);
    bus(1'b0, 12'h000, 32'h0, 1'b0, 32'h17);
    bus(1'b1, 12'h008, 32'h1230, 1'b0, 32'h0);
    op(cpu_regs_pkg::OP_STACK_ADJUST, 16'h00fe, 1'b0);
    bus(1'b0, 12'h008, 32'h0, 1'b0, 32'h122e);
    op(cpu_regs_pkg::OP_STACK_POINTER_RESET, 16'h0, 1'b0);
    bus(1'b0, 12'h008, 32'h0, 1'b0, 32'h12ff);
    op(cpu_regs_pkg::OP_PUSH, 16'h0, 1'b0);
    bus(1'b0, 12'h008, 32'h0, 1'b0, 32'h12fe);
    op(cpu_regs_pkg::OP_JUMP, 16'h4000, 1'b0);
    op(cpu_regs_pkg::OP_FETCH, 16'h0, 1'b0);
    op(cpu_regs_pkg::OP_BRANCH, 16'h00fe, 1'b0);
    bus(1'b0, 12'h00c, 32'h0, 1'b0, 32'h3fff);
    op(cpu_regs_pkg::OP_LOAD_ACC, 16'h0080, 1'b0);
    bus(1'b0, 12'h010, 32'h0, 1'b0, 32'h7c);
    bus(1'b1, 12'h010, 32'h08, 1'b0, 32'h0);
    bus(1'b0, 12'h010, 32'h0, 1'b0, 32'h68);
    irq_pending <= 1'b1;
    op(cpu_regs_pkg::OP_MASK_CLEAR, 16'h0, 1'b0);
    bus(1'b0, 12'h010, 32'h0, 1'b0, 32'h60);
    exp_irq <= 1'b1;
    op(cpu_regs_pkg::OP_NOP, 16'h0, 1'b0);
    exp_irq <= 1'b0;
    op(cpu_regs_pkg::OP_INT_SAVED, 16'h0, 1'b0);
    bus(1'b0, 12'h010, 32'h0, 1'b0, 32'h68);
    bus(1'b0, 12'h020, 32'h0, 1'b1, 32'h0);
    bus(1'b1, 12'h024, 32'hffff_ffff, 1'b1, 32'h0);
    do_reset();
    bus(1'b0, 12'h004, 32'h0, 1'b0, 32'h00ce);
    bus(1'b0, 12'h000, 32'h0, 1'b0, 32'h80);
    bus(1'b0, 12'h008, 32'h0, 1'b0, 32'h00ff);
    give_verdict();
  end
endmodule

// ==== test/cpu_register_set_asserts.sv ====
`timescale 1ns/1ps
module cpu_register_set_asserts (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // Operations
  input wire logic              op_valid,
  input wire cpu_regs_pkg::op_t op_code,
  input wire logic [15:0]       op_data,
  input wire logic              run_enable,
  input wire logic              irq_accept,
  // Register views
  input wire logic [7:0]        acc_value,
  input wire logic [15:0]       index_value,
  input wire logic [15:0]       stack_value,
  input wire logic [7:0]        flags_value
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       taken;
  logic [8:0] sum;
  assign taken = op_valid && run_enable;
  assign sum   = acc_value + op_data[7:0];
  sequence cleared;
    taken && op_code == cpu_regs_pkg::OP_MASK_CLEAR && flags_value[3];
  endsequence
  sequence quiet;
    !flags_value[3] && !irq_accept;
  endsequence
  AST_RESET_VALUES: assert property ($rose(presetn) |-> stack_value == 16'h00ff &&
    index_value[15:8] == 8'h00) else $error("reset values wrong");
  AST_FIXED_ONES: assert property (flags_value[6:5] == 2'b11)
    else $error("fixed flag bits not one");
  AST_MASK_BLOCKS: assert property (irq_accept |-> !flags_value[3])
    else $error("interrupt accepted while masked");
  AST_MASK_CLEAR: assert property (cleared |=> quiet)
    else $error("interrupt accepted at boundary after mask clear");
  AST_INT_SAVED: assert property (taken && op_code == cpu_regs_pkg::OP_INT_SAVED
    |=> flags_value[3]) else $error("mask not set after stacking");
  AST_ADD: assert property (taken && op_code == cpu_regs_pkg::OP_ADD |=>
    acc_value == $past(sum[7:0]) && flags_value[0] == $past(sum[8])) else $error("add wrong");
  AST_LOAD_FLAGS: assert property (taken && op_code == cpu_regs_pkg::OP_LOAD_ACC |=>
    flags_value[2:1] == {$past(op_data[7]), $past(op_data[7:0]) == 8'h00})
    else $error("load flags wrong");
  AST_STACK_ADJUST: assert property (taken && op_code == cpu_regs_pkg::OP_STACK_ADJUST |=>
    stack_value == $past(stack_value) + {{8{$past(op_data[7])}}, $past(op_data[7:0])})
    else $error("stack adjust wrong");
  AST_STACK_RESET_OP: assert property (taken && op_code == cpu_regs_pkg::OP_STACK_POINTER_RESET
    |=> stack_value == {$past(stack_value[15:8]), 8'hff}) else $error("stack reset op wrong");
endmodule
bind cpu_register_set cpu_register_set_asserts u_chk (.pclk, .presetn, .op_valid, .op_code,
  .op_data, .run_enable, .irq_accept, .acc_value, .index_value, .stack_value, .flags_value);
